/* rtl/sis_exec.sv */
// Flag, immediate-write and side-set executor with its AXI4-Lite registers.
// Function
// - Clear bit zero raises flag, one lowers it.
// - Clear set means Wait is ignored.
// - Raise with Wait stalls until flag drops.
// - Low three index bits pick flag 0-7.
// - Relative index adds machine number modulo four.
// - Flags 0-3 route to two masked lines.
// - Delay counting starts after the wait ends.
// - Opcode 111 marks immediate write; fixed fields.
// - Destination codes pick pins, X, Y, directions.
// - Scratch write loads five bits, zeroes rest.
// - Immediate operand is five bits, 0-31.
// - Immediate pin mapping separate from shift-out mapping.
// - Side-set drives up to five pins concurrently.
// - Side-set wins over shift-out or immediate write.
// - Side-set acts at once even when stalling.
// - Count gives side-set bits; rest is delay.
// - Enable option makes top bit per-instruction enable.
// - First GPIO gets lowest side-set bit, ascending.
// - Direction select picks levels or output enables.
`timescale 1ns/10ps
module sis_exec (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instruction stream from the fetch stage
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic sm_stalled,
  // Pin writes from the shift-out unit, already mapped
  input wire logic [31:0] out_lvl_data,
  input wire logic [31:0] out_lvl_mask,
  input wire logic [31:0] out_dir_data,
  input wire logic [31:0] out_dir_mask,
  // GPIO levels and directions
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  // Flags shared with sibling state machines
  input wire logic [7:0] flag_set_in,
  input wire logic [7:0] flag_clr_in,
  output logic [7:0] flag_state,
  // System interrupt request lines
  output logic irq_req0,
  output logic irq_req1,
  // Scratch registers toward the rest of the machine
  output logic [31:0] scratch_x,
  output logic [31:0] scratch_y
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] low_mask(input logic [5:0] n);
    logic [32:0] t;
    t = (33'h1 << n) - 33'h1;
    return t[31:0];
  endfunction

  function automatic logic [31:0] rotl32(input logic [31:0] x,
                                         input logic [4:0] sh);
    logic [63:0] t;
    t = {x, x} << sh;
    return t[63:32];
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  sis_pkg::sis_regs_t r;
  sis_pkg::sis_regs_t next_r;

  logic accept;
  logic [2:0] opc;
  logic [4:0] ds_field;
  logic [2:0] delay_w;
  logic [2:0] ss_w;
  logic ss_on;
  logic [4:0] ss_val;
  logic [4:0] delay_val;
  logic [31:0] ss_mask;
  logic [31:0] ss_data;
  logic [2:0] flag_idx;
  logic [1:0] rel_sum;
  logic [7:0] set_hits;
  logic [7:0] clr_hits;
  logic is_flag;
  logic flag_wait;
  logic is_imm;
  logic [2:0] imm_dest;
  logic [31:0] imm_mask;
  logic [31:0] imm_data;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] cfg_word;
  logic [31:0] sts_word;
  logic [31:0] cfg_new;
  logic [7:0] bus_clr;

  assign s_axi_awready = ce && !r.aw_held && !r.bvalid;
  assign s_axi_wready = ce && !r.w_held && !r.bvalid;
  assign s_axi_arready = ce && !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign instr_ready = ce && (r.state == sis_pkg::ST_RUN);
  assign sm_stalled = (r.state != sis_pkg::ST_RUN);
  assign pin_out = r.pin_lvl;
  assign pin_oe = r.pin_dir;
  assign flag_state = r.flags;
  assign scratch_x = r.scr_x;
  assign scratch_y = r.scr_y;
  // Flags 4-7 never reach the interrupt lines.
  assign irq_req0 = |(r.flags[3:0] & r.irq_line0_enable_mask);
  assign irq_req1 = |(r.flags[3:0] & r.irq_line1_enable_mask);

  // ****************************************************************
  // Register views
  // ****************************************************************
  always_comb
  begin
    cfg_word = sis_pkg::WORD_ZERO;
    cfg_word[sis_pkg::CFG_SSCNT_LSB +: 3] = r.sideset_bit_count;
    cfg_word[sis_pkg::CFG_SSEN_BIT] = r.sideset_enable_option;
    cfg_word[sis_pkg::CFG_SSDIR_BIT] = r.sideset_direction_select;
    cfg_word[sis_pkg::CFG_SSBASE_LSB +: 5] = r.sideset_first_gpio;
    cfg_word[sis_pkg::CFG_SETBASE_LSB +: 5] = r.set_first_gpio;
    cfg_word[sis_pkg::CFG_SETCNT_LSB +: 3] = r.set_pin_count;
    cfg_word[sis_pkg::CFG_SMNUM_LSB +: 2] = r.sm_number;
    sts_word = sis_pkg::WORD_ZERO;
    sts_word[sis_pkg::STS_STATE_LSB +: 2] = r.state;
    sts_word[sis_pkg::STS_DELAY_LSB +: 5] = r.delay_cnt;
    sts_word[sis_pkg::STS_WAITIDX_LSB +: 3] = r.wait_idx;
  end

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  always_comb
  begin
    accept = instr_valid && instr_ready;
    opc = instr[sis_pkg::OPC_MSB:sis_pkg::OPC_LSB];
    ds_field = instr[sis_pkg::DS_MSB:sis_pkg::DS_LSB];
    // The top count bits are side-set, the rest are delay.
    delay_w = sis_pkg::DS_BITS - r.sideset_bit_count;
    ss_val = ds_field >> delay_w;
    delay_val = ds_field & 5'(low_mask({3'h0, delay_w}));
    ss_w = r.sideset_bit_count;
    ss_on = (r.sideset_bit_count != 3'h0);
    if (r.sideset_enable_option && ss_on)
    begin
      ss_w = r.sideset_bit_count - 3'h1;
      ss_on = ds_field[sis_pkg::DS_MSB - sis_pkg::DS_LSB];
    end
    ss_val = ss_val & 5'(low_mask({3'h0, ss_w}));
    ss_mask = rotl32(low_mask({3'h0, ss_w}), r.sideset_first_gpio);
    ss_data = rotl32({27'h0, ss_val}, r.sideset_first_gpio);
    is_flag = (opc == sis_pkg::OPC_IRQ) && !instr[sis_pkg::IRQ_ZERO_BIT];
    flag_idx = instr[2:0];
    rel_sum = instr[1:0] + r.sm_number;
    if (instr[sis_pkg::IRQ_REL_BIT])
    begin
      flag_idx = {instr[2], rel_sum};
    end
    // A clearing flag op never waits.
    flag_wait = is_flag && instr[sis_pkg::IRQ_WAIT_BIT]
                && !instr[sis_pkg::IRQ_CLR_BIT];
    set_hits = flag_set_in;
    clr_hits = flag_clr_in;
    if (accept && is_flag && !instr[sis_pkg::IRQ_CLR_BIT])
    begin
      set_hits[flag_idx] = 1'b1;
    end
    if (accept && is_flag && instr[sis_pkg::IRQ_CLR_BIT])
    begin
      clr_hits[flag_idx] = 1'b1;
    end
    is_imm = (opc == sis_pkg::OPC_SET);
    imm_dest = instr[sis_pkg::DEST_MSB:sis_pkg::DEST_LSB];
    // The immediate path has its own base and width, apart from shift-out.
    imm_mask = rotl32(low_mask({3'h0, r.set_pin_count}),
                      r.set_first_gpio);
    imm_data = rotl32({27'h0, instr[sis_pkg::DATA_MSB:0]},
                      r.set_first_gpio);
  end

  // ****************************************************************
  // Bus write path
  // ****************************************************************
  always_comb
  begin
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    ar_hs = s_axi_arvalid && s_axi_arready;
    do_write = (r.aw_held || aw_hs) && (r.w_held || w_hs);
    wr_addr = r.aw_held ? r.aw_addr : s_axi_awaddr;
    wr_data = r.w_held ? r.w_data : s_axi_wdata;
    wr_strb = r.w_held ? r.w_strb : s_axi_wstrb;
    cfg_new = merge_strb(cfg_word, wr_data, wr_strb);
    bus_clr = 8'h00;
    if (do_write && (wr_addr == sis_pkg::REG_FLAGS) && wr_strb[0])
    begin
      bus_clr = wr_data[7:0];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    if (ce)
    begin
      // A flag raised in the cycle it is cleared stays raised.
      next_r.flags = (r.flags & ~(clr_hits | bus_clr)) | set_hits;

      case (r.state)
        sis_pkg::ST_RUN:
        begin
          if (accept && flag_wait)
          begin
            next_r.state = sis_pkg::ST_WAIT;
            next_r.wait_idx = flag_idx;
            next_r.delay_cnt = delay_val;
          end
          else if (accept && (delay_val != 5'h00))
          begin
            next_r.state = sis_pkg::ST_DELAY;
            next_r.delay_cnt = delay_val;
          end
        end
        sis_pkg::ST_WAIT:
        begin
          if (!r.flags[r.wait_idx])
          begin
            next_r.state = (r.delay_cnt != 5'h00) ? sis_pkg::ST_DELAY
                                                  : sis_pkg::ST_RUN;
          end
        end
        sis_pkg::ST_DELAY:
        begin
          next_r.delay_cnt = r.delay_cnt - sis_pkg::DELAY_ONE;
          if (r.delay_cnt == sis_pkg::DELAY_ONE)
          begin
            next_r.state = sis_pkg::ST_RUN;
          end
        end
        default:
        begin
          next_r.state = sis_pkg::ST_RUN;
        end
      endcase

      // Pin writes land in priority order: shift-out, immediate, side-set.
      next_r.pin_lvl = (r.pin_lvl & ~out_lvl_mask) | (out_lvl_data & out_lvl_mask);
      next_r.pin_dir = (r.pin_dir & ~out_dir_mask) | (out_dir_data & out_dir_mask);
      if (accept && is_imm)
      begin
        case (imm_dest)
          sis_pkg::DST_PINS:
          begin
            next_r.pin_lvl = (next_r.pin_lvl & ~imm_mask)
                             | (imm_data & imm_mask);
          end
          sis_pkg::DST_X:
          begin
            next_r.scr_x = {27'h0, instr[sis_pkg::DATA_MSB:0]};
          end
          sis_pkg::DST_Y:
          begin
            next_r.scr_y = {27'h0, instr[sis_pkg::DATA_MSB:0]};
          end
          sis_pkg::DST_PINDIRS:
          begin
            next_r.pin_dir = (next_r.pin_dir & ~imm_mask)
                             | (imm_data & imm_mask);
          end
          default:
          begin
            next_r.scr_x = r.scr_x;
          end
        endcase
      end
      // Side-set is applied on acceptance, so a stall that follows cannot
      // hold it back; it is written last so it overrides other writers.
      if (accept && ss_on)
      begin
        if (r.sideset_direction_select)
        begin
          next_r.pin_dir = (next_r.pin_dir & ~ss_mask)
                           | (ss_data & ss_mask);
        end
        else
        begin
          next_r.pin_lvl = (next_r.pin_lvl & ~ss_mask)
                           | (ss_data & ss_mask);
        end
      end

      // AXI4-Lite write channel capture and response.
      if (aw_hs && !do_write)
      begin
        next_r.aw_held = 1'b1;
        next_r.aw_addr = s_axi_awaddr;
      end
      if (w_hs && !do_write)
      begin
        next_r.w_held = 1'b1;
        next_r.w_data = s_axi_wdata;
        next_r.w_strb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
      begin
        next_r.bvalid = 1'b0;
      end
      if (do_write)
      begin
        next_r.aw_held = 1'b0;
        next_r.w_held = 1'b0;
        next_r.bvalid = 1'b1;
        next_r.bresp = sis_pkg::RESP_OKAY;
        case (wr_addr)
          sis_pkg::REG_CFG:
          begin
            // Counts above five would reach into the opcode, so they clamp.
            next_r.sideset_bit_count = cfg_new[sis_pkg::CFG_SSCNT_LSB +: 3];
            if (cfg_new[sis_pkg::CFG_SSCNT_LSB +: 3] > sis_pkg::DS_BITS)
            begin
              next_r.sideset_bit_count = sis_pkg::DS_BITS;
            end
            next_r.sideset_enable_option = cfg_new[sis_pkg::CFG_SSEN_BIT];
            next_r.sideset_direction_select = cfg_new[sis_pkg::CFG_SSDIR_BIT];
            next_r.sideset_first_gpio = cfg_new[sis_pkg::CFG_SSBASE_LSB +: 5];
            next_r.set_first_gpio = cfg_new[sis_pkg::CFG_SETBASE_LSB +: 5];
            next_r.set_pin_count = cfg_new[sis_pkg::CFG_SETCNT_LSB +: 3];
            if (cfg_new[sis_pkg::CFG_SETCNT_LSB +: 3] > sis_pkg::DS_BITS)
            begin
              next_r.set_pin_count = sis_pkg::DS_BITS;
            end
            next_r.sm_number = cfg_new[sis_pkg::CFG_SMNUM_LSB +: 2];
          end
          sis_pkg::REG_FLAGS:
          begin
            next_r.bresp = sis_pkg::RESP_OKAY;
          end
          sis_pkg::REG_MASK0:
          begin
            if (wr_strb[0])
            begin
              next_r.irq_line0_enable_mask = wr_data[3:0];
            end
          end
          sis_pkg::REG_MASK1:
          begin
            if (wr_strb[0])
            begin
              next_r.irq_line1_enable_mask = wr_data[3:0];
            end
          end
          default:
          begin
            next_r.bresp = sis_pkg::RESP_SLVERR;
          end
        endcase
      end

      // AXI4-Lite read channel.
      if (r.rvalid && s_axi_rready)
      begin
        next_r.rvalid = 1'b0;
      end
      if (ar_hs)
      begin
        next_r.rvalid = 1'b1;
        next_r.rresp = sis_pkg::RESP_OKAY;
        case (s_axi_araddr)
          sis_pkg::REG_CFG: next_r.rdata = cfg_word;
          sis_pkg::REG_FLAGS: next_r.rdata = {24'h0, r.flags};
          sis_pkg::REG_MASK0: next_r.rdata = {28'h0, r.irq_line0_enable_mask};
          sis_pkg::REG_MASK1: next_r.rdata = {28'h0, r.irq_line1_enable_mask};
          sis_pkg::REG_SCR_X: next_r.rdata = r.scr_x;
          sis_pkg::REG_SCR_Y: next_r.rdata = r.scr_y;
          sis_pkg::REG_STATUS: next_r.rdata = sts_word;
          default:
          begin
            next_r.rdata = sis_pkg::WORD_ZERO;
            next_r.rresp = sis_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Every field resets to zero; the idle state is encoded as zero.
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule

/* shared/sis_pkg.sv */
// Shared constants and state types for the flag, immediate-write and side-set executor.
package sis_pkg;

  // ****************************************************************
  // Register map, byte addresses on the AXI4-Lite port
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_MASK0 = 8'h08;
  localparam logic [7:0] REG_MASK1 = 8'h0c;
  localparam logic [7:0] REG_SCR_X = 8'h10;
  localparam logic [7:0] REG_SCR_Y = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // ****************************************************************
  // Field positions inside the configuration and status words
  // ****************************************************************
  localparam int CFG_SSCNT_LSB = 0;
  localparam int CFG_SSEN_BIT = 3;
  localparam int CFG_SSDIR_BIT = 4;
  localparam int CFG_SSBASE_LSB = 8;
  localparam int CFG_SETBASE_LSB = 16;
  localparam int CFG_SETCNT_LSB = 21;
  localparam int CFG_SMNUM_LSB = 24;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_DELAY_LSB = 4;
  localparam int STS_WAITIDX_LSB = 12;

  // ****************************************************************
  // Instruction encoding
  // ****************************************************************
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 13;
  localparam int DS_MSB = 12;
  localparam int DS_LSB = 8;
  localparam int IRQ_ZERO_BIT = 7;
  localparam int IRQ_CLR_BIT = 6;
  localparam int IRQ_WAIT_BIT = 5;
  localparam int IRQ_REL_BIT = 4;
  localparam int DEST_MSB = 7;
  localparam int DEST_LSB = 5;
  localparam int DATA_MSB = 4;
  localparam logic [2:0] OPC_IRQ = 3'h6;
  localparam logic [2:0] OPC_SET = 3'h7;
  localparam logic [2:0] DST_PINS = 3'h0;
  localparam logic [2:0] DST_X = 3'h1;
  localparam logic [2:0] DST_Y = 3'h2;
  localparam logic [2:0] DST_PINDIRS = 3'h4;
  localparam logic [2:0] DS_BITS = 3'h5;
  localparam logic [4:0] DELAY_ONE = 5'h01;

  // ****************************************************************
  // Bus answers and reset values
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_DELAY} sis_state_t;

  typedef struct packed {
    sis_state_t state;
    logic [4:0] delay_cnt;
    logic [2:0] wait_idx;
    logic [7:0] flags;
    logic [31:0] scr_x;
    logic [31:0] scr_y;
    logic [31:0] pin_lvl;
    logic [31:0] pin_dir;
    logic [2:0] sideset_bit_count;
    logic sideset_enable_option;
    logic sideset_direction_select;
    logic [4:0] sideset_first_gpio;
    logic [4:0] set_first_gpio;
    logic [2:0] set_pin_count;
    logic [1:0] sm_number;
    logic [3:0] irq_line0_enable_mask;
    logic [3:0] irq_line1_enable_mask;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sis_regs_t;

endpackage

/* testbench/sis_exec_chk.sv */
// Assertions on the executor's instruction, flag and scratch ports.
`timescale 1ns/10ps
module sis_exec_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Instruction port
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic sm_stalled,
  // Flags, lines and scratch
  input wire logic [7:0] flag_set_in,
  input wire logic [7:0] flag_state,
  input wire logic irq_req0,
  input wire logic irq_req1,
  input wire logic [31:0] scratch_x,
  input wire logic [31:0] scratch_y
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic go;
  logic fl;
  logic st;
  assign go = instr_valid && instr_ready;
  assign fl = go && instr[15:13] == 3'h6 && !instr[4];
  assign st = go && instr[15:13] == 3'h7;
  a_flag_raise: assert property (
    fl && !instr[6] |=> flag_state[$past(instr[2:0])])
    else $error("flag not raised");
  a_flag_clear: assert property (
    fl && instr[6] && flag_set_in == 8'h00
    |=> !flag_state[$past(instr[2:0])])
    else $error("flag not lowered");
  a_clear_nowait: assert property (
    fl && instr[6] && instr[12:8] == 5'h00 |=> !sm_stalled)
    else $error("clear stalled");
  a_wait_stall: assert property (
    fl && !instr[6] && instr[5] |=> sm_stalled)
    else $error("raise with wait did not stall");
  a_set_x: assert property (
    st && instr[7:5] == 3'h1 |=> scratch_x == {27'h0, $past(instr[4:0])})
    else $error("scratch x wrong");
  a_set_y: assert property (
    st && instr[7:5] == 3'h2 |=> scratch_y == {27'h0, $past(instr[4:0])})
    else $error("scratch y wrong");
  a_other_keeps: assert property (
    go && instr[15:13] != 3'h7 |=> $stable(scratch_x) && $stable(scratch_y))
    else $error("scratch changed");
  a_line_source: assert property (
    irq_req0 || irq_req1 |-> flag_state[3:0] != 4'h0)
    else $error("line raised without low flag");
  a_no_delay: assert property (
    go && instr[12:8] == 5'h00 && !instr[5] |=> !sm_stalled)
    else $error("stalled with no delay");
endmodule
bind sis_exec sis_exec_chk i_sis_exec_chk (.aclk, .aresetn, .instr,
  .instr_valid, .instr_ready, .sm_stalled, .flag_set_in, .flag_state,
  .irq_req0, .irq_req1, .scratch_x, .scratch_y);

/* testbench/sis_far.sv */
// Model of the sibling machines and the shift-out unit beside the executor.
`timescale 1ns/10ps
module sis_far (
  // Clock
  input wire logic aclk,
  // Flag requests from siblings
  output logic [7:0] flag_set_in,
  output logic [7:0] flag_clr_in,
  // Mapped shift-out pin writes
  output logic [31:0] out_lvl_data,
  output logic [31:0] out_lvl_mask,
  output logic [31:0] out_dir_data,
  output logic [31:0] out_dir_mask
);
  initial
  begin
    flag_set_in = 8'h00;
    flag_clr_in = 8'h00;
    out_lvl_data = 32'h0;
    out_lvl_mask = 32'h0;
    out_dir_data = 32'h0;
    out_dir_mask = 32'h0;
  end
  // A sibling request lasts one cycle, like the real pulse.
  task automatic pulse(input logic [7:0] s, input logic [7:0] c);
    @(posedge aclk);
    flag_set_in <= s;
    flag_clr_in <= c;
    @(posedge aclk);
    flag_set_in <= 8'h00;
    flag_clr_in <= 8'h00;
  endtask
  // Released data is inverted so a stale value cannot pass for a match.
  task automatic shift(input logic [31:0] d, input logic [31:0] m);
    @(posedge aclk);
    out_lvl_data <= d;
    out_lvl_mask <= m;
    out_dir_data <= d;
    out_dir_mask <= m;
    @(posedge aclk);
    out_lvl_data <= ~d;
    out_lvl_mask <= 32'h0;
    out_dir_data <= ~d;
    out_dir_mask <= 32'h0;
  endtask
endmodule

/* testbench/sis_exec_tb.sv */
// Self-checking bench for the flag, immediate-write and side-set executor.
`timescale 1ns/10ps
module sis_exec_tb;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, t;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, instr_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, instr_ready, sm_stalled, irq_req0, irq_req1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pin_out, pin_oe, rd;
  logic [31:0] out_lvl_data, out_lvl_mask, out_dir_data, out_dir_mask;
  logic [31:0] scratch_x, scratch_y;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] instr = 16'h0;
  logic [7:0] flag_set_in, flag_clr_in, flag_state;
  logic [15:0] sw [8] = '{16'he015, 16'he08a, 16'he03f, 16'he047,
    16'he07e, 16'he0be, 16'he0de, 16'he0fe};
  logic [15:0] iw [4] = '{16'hc011, 16'hc013, 16'hc016, 16'hc041};
  logic [7:0] fe [4] = '{8'h08, 8'h0a, 8'h1a, 8'h18};
  int err_count = 0, checks_done = 0, cyc = 0, n0, n2;
  always #10 aclk = ~aclk;
  sis_exec i_sis_exec (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .instr, .instr_valid, .instr_ready, .sm_stalled,
    .out_lvl_data, .out_lvl_mask, .out_dir_data, .out_dir_mask, .pin_out,
    .pin_oe, .flag_set_in, .flag_clr_in, .flag_state, .irq_req0,
    .irq_req1, .scratch_x, .scratch_y);
  sis_far i_sis_far (.aclk, .flag_set_in, .flag_clr_in, .out_lvl_data,
    .out_lvl_mask, .out_dir_data, .out_dir_mask);
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Readiness is sampled at the falling edge, where it has settled.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      t = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid,
        s_axi_bvalid};
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (t[2])
        s_axi_awvalid <= 1'b0;
      if (t[1])
        s_axi_wvalid <= 1'b0;
      if (t[0])
      begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      t = {s_axi_arready & s_axi_arvalid, 1'b0, s_axi_rvalid};
      rsp = s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (t[2])
        s_axi_arvalid <= 1'b0;
      if (t[0])
      begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
  endtask
  task automatic ex(input logic [15:0] w);
    @(posedge aclk);
    instr <= w;
    instr_valid <= 1'b1;
    forever
    begin
      @(negedge aclk);
      t[0] = instr_ready;
      @(posedge aclk);
      if (t[0])
      begin
        instr_valid <= 1'b0;
        return;
      end
    end
  endtask
  // Issues a waiting raise, lowers the flag from a sibling, counts cycles.
  task automatic wait_rel(input logic [15:0] w, input logic [7:0] f,
    output int n);
    ex(w);
    @(negedge aclk);
    chk("stall", 32'h1, {31'h0, sm_stalled});
    chk("oe at stall", 32'ha0, pin_oe);
    repeat (4) @(negedge aclk);
    chk("still stalled", 32'h1, {31'h0, sm_stalled});
    i_sis_far.pulse(8'h00, f);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!instr_ready && n < 40);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(sis_pkg::REG_CFG);
    chk("cfg reset", 32'h0, rd);
    wr_reg(sis_pkg::REG_CFG, 32'h02a40000);
    for (int i = 0; i < 8; i++)
      ex(sw[i]);
    @(negedge aclk);
    chk("pins", 32'h150, pin_out);
    chk("dirs", 32'ha0, pin_oe);
    chk("x", 32'h1f, scratch_x);
    chk("y", 32'h7, scratch_y);
    rd_reg(sis_pkg::REG_SCR_X);
    chk("x read", 32'h1f, rd);
    wr_reg(sis_pkg::REG_SCR_X, 32'h0);
    chk("ro write", 32'h2, {30'h0, rsp});
    rd_reg(8'h1c);
    chk("unmapped", 32'h2, {30'h0, rsp});
    $display("test immediate done");
    for (int i = 0; i < 4; i++)
    begin
      ex(iw[i]);
      @(negedge aclk);
      chk("flags", {24'h0, fe[i]}, {24'h0, flag_state});
    end
    wr_reg(sis_pkg::REG_MASK0, 32'h8);
    wr_reg(sis_pkg::REG_MASK1, 32'h2);
    @(negedge aclk);
    chk("line0", 32'h1, {31'h0, irq_req0});
    chk("line1", 32'h0, {31'h0, irq_req1});
    wr_reg(sis_pkg::REG_MASK0, 32'hf);
    ex(16'hc063);
    @(negedge aclk);
    chk("clear wait", 32'h10, {23'h0, sm_stalled, flag_state});
    chk("line0 off", 32'h0, {31'h0, irq_req0});
    $display("test flags done");
    wait_rel(16'hc022, 8'h04, n0);
    wait_rel(16'hc222, 8'h04, n2);
    chk("wait delay", n0 + 2, n2);
    $display("test wait done");
    wr_reg(sis_pkg::REG_CFG, 32'h02b41402);
    ex(16'he81f);
    @(negedge aclk);
    chk("side level", 32'h01d00150, pin_out);
    wr_reg(sis_pkg::REG_CFG, 32'h02b4141a);
    ex(16'h1800);
    ex(16'h0000);
    @(negedge aclk);
    chk("side dir", 32'h001000a0, pin_oe);
    ex(16'h0b00);
    n0 = 0;
    @(negedge aclk);
    while (!instr_ready && n0 < 20)
    begin
      n0++;
      @(negedge aclk);
    end
    chk("delay", 32'd3, n0);
    wait_rel(16'hd025, 8'h20, n2);
    i_sis_far.shift(32'h200, 32'h200);
    @(negedge aclk);
    chk("shift lvl", 32'h01d00350, pin_out);
    chk("shift dir", 32'h2a0, pin_oe);
    @(posedge aclk);
    ce <= 1'b0;
    i_sis_far.shift(32'h1, 32'h1);
    @(negedge aclk);
    chk("ce hold", 32'h01d00350, pin_out);
    $display("test side-set done");
    give_verdict();
  end
endmodule
